// ==== rtl/lbm_bus_master_port.sv ====
// bus master port: request/grant, strobe/ready cycles, lock and throttle timer
module lbm_bus_master_port import lbm_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // user side request and answer
  input wire logic req_valid,
  input wire lbm_req_s req,
  output logic req_ready,
  output logic rsp_done,
  output logic [LBM_DATA_W-1:0] rsp_rdata,
  // configuration and status
  input wire logic cfg_lock_disable,
  input wire logic cfg_little_endian,
  input wire logic cfg_throttle_ext,
  input wire logic [LBM_TIMER_W-1:0] cfg_tenure_limit,
  output logic bus_owned,
  // arbitration pins
  output logic bus_request,
  input wire logic bus_grant_in,
  input wire logic throttle_trigger_in,
  // cycle control pins
  input wire logic ready_b_in,
  input wire logic bus_width_select,
  output logic address_strobe_b,
  output logic address_strobe_oe,
  output logic wr_sel,
  output logic wr_sel_oe,
  output logic lock_b,
  output logic lock_oe,
  // address and data pins
  output logic [LBM_ADDR_W-1:0] addr_out,
  output logic addr_oe,
  output logic [LBM_DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [LBM_DATA_W-1:0] data_in
);

  //------------------------------------------------------------
  // lane steering
  //------------------------------------------------------------

  // move the low half onto the high lanes for 16-bit big endian
  function automatic logic [LBM_DATA_W-1:0] lane_place(input logic [LBM_DATA_W-1:0] d,
                                                       input logic wide, input logic le);
    if (wide || le) begin
      lane_place = d;
    end else begin
      lane_place = {d[LBM_HALF_W-1:0], d[LBM_HALF_W-1:0]};
    end
  endfunction

  // pick the live half of read data in 16-bit mode
  function automatic logic [LBM_DATA_W-1:0] lane_pick(input logic [LBM_DATA_W-1:0] d,
                                                      input logic wide, input logic le);
    if (wide) begin
      lane_pick = d;
    end else if (le) begin
      lane_pick = {{LBM_HALF_W{1'h0}}, d[LBM_HALF_W-1:0]};
    end else begin
      lane_pick = {{LBM_HALF_W{1'h0}}, d[LBM_DATA_W-1:LBM_HALF_W]};
    end
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------

  lbm_state_e state, next_state;
  logic [LBM_SYNC_STAGES-1:0] grant_sync;
  logic grant_s;
  logic trig_prev, next_trig_prev;
  logic timer_run, next_timer_run;
  logic [LBM_TIMER_W-1:0] tenure_cnt, next_tenure_cnt;
  logic expired, next_expired;
  logic lock_active, next_lock_active;
  logic cur_lock_last, next_cur_lock_last;
  logic next_req_ready, next_rsp_done, next_bus_owned, next_bus_request;
  logic next_address_strobe_b, next_wr_sel, next_lock_b, next_data_oe;
  logic [LBM_DATA_W-1:0] next_rsp_rdata, next_data_out;
  logic [LBM_ADDR_W-1:0] next_addr_out;
  logic release_due;

  // grant arrives from another clocking world, so only the last stage is read
  assign grant_s = grant_sync[LBM_SYNC_STAGES-1];
  assign release_due = !grant_s || expired;

  // next values for the whole port
  always_comb begin
    next_state = state;
    next_trig_prev = throttle_trigger_in;
    next_timer_run = timer_run;
    next_tenure_cnt = tenure_cnt;
    next_expired = expired;
    next_lock_active = lock_active;
    next_cur_lock_last = cur_lock_last;
    next_rsp_done = 1'h0;
    next_rsp_rdata = rsp_rdata;
    next_wr_sel = wr_sel;
    next_addr_out = addr_out;
    next_data_out = data_out;
    case (state)
      LBM_IDLE: begin
        if (req_valid) begin
          next_state = LBM_REQ;
        end
      end
      LBM_REQ: begin
        // wait for the synchronised grant before owning
        if (grant_s) begin
          next_state = LBM_OWN;
        end
      end
      LBM_OWN: begin
        // R10 R12: grant loss or timer expiry ends the tenure
        if (release_due) begin
          next_state = LBM_REL;
        // R16: cycles only start from the owned state
        end else if (req_valid && req_ready) begin
          next_state = LBM_ADDR;
          next_wr_sel = req.write;
          next_addr_out = req.addr;
          next_data_out = lane_place(req.wdata, bus_width_select, cfg_little_endian);
          next_cur_lock_last = req.lock_last;
          // R6: lock held off when disabled
          if (req.locked && !cfg_lock_disable) begin
            next_lock_active = 1'h1;
          end
        end else if (!req_valid) begin
          next_state = LBM_REL;
        end
      end
      LBM_ADDR: begin
        // R4: ready is not looked at in the address state
        next_state = LBM_DATA;
      end
      LBM_DATA: begin
        // R5: last locked cycle drops lock in its data state
        if (cur_lock_last) begin
          next_lock_active = 1'h0;
        end
        // R3: low ready ends the transfer, high inserts a wait
        if (!ready_b_in) begin
          next_rsp_done = 1'h1;
          // R8: read half chosen by width and byte order
          next_rsp_rdata = lane_pick(data_in, bus_width_select, cfg_little_endian);
          next_state = release_due ? LBM_REL : LBM_OWN;
        end
      end
      LBM_REL: begin
        // R9: request already low, wait for the grant to follow
        next_lock_active = 1'h0;
        if (!grant_s) begin
          next_state = LBM_IDLE;
        end
      end
      default: begin
        next_state = LBM_IDLE;
      end
    endcase
    // R14: throttle timer start, on grant or on the external trigger edge
    if (state == LBM_IDLE || state == LBM_REL) begin
      next_timer_run = 1'h0;
      next_tenure_cnt = '0;
      next_expired = 1'h0;
    end else if (!timer_run) begin
      if (cfg_throttle_ext ? (throttle_trigger_in && !trig_prev) : (state == LBM_OWN)) begin
        next_timer_run = 1'h1;
      end
    end else if (cfg_tenure_limit != '0) begin
      if (tenure_cnt >= cfg_tenure_limit - LBM_TIMER_W'(1)) begin
        next_expired = 1'h1;
      end else begin
        next_tenure_cnt = tenure_cnt + LBM_TIMER_W'(1);
      end
    end
    // registered pin and status images of the next state
    next_bus_owned = (next_state == LBM_OWN) || (next_state == LBM_ADDR) || (next_state == LBM_DATA);
    next_bus_request = (next_state == LBM_REQ) || next_bus_owned;
    next_req_ready = (next_state == LBM_OWN) && !next_expired;
    // R2: strobe low exactly in the address state
    next_address_strobe_b = !(next_state == LBM_ADDR);
    next_lock_b = !(next_lock_active && next_bus_owned);
    next_data_oe = next_bus_owned && next_wr_sel && (next_state != LBM_OWN);
  end

  // registers only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state <= LBM_IDLE;
      grant_sync <= '0;
      trig_prev <= 1'h0;
      timer_run <= 1'h0;
      tenure_cnt <= '0;
      expired <= 1'h0;
      lock_active <= 1'h0;
      cur_lock_last <= 1'h0;
      req_ready <= 1'h0;
      rsp_done <= 1'h0;
      rsp_rdata <= '0;
      bus_owned <= 1'h0;
      bus_request <= 1'h0;
      address_strobe_b <= LBM_STROBE_IDLE;
      address_strobe_oe <= 1'h0;
      wr_sel <= 1'h0;
      wr_sel_oe <= 1'h0;
      lock_b <= LBM_LOCK_IDLE;
      lock_oe <= 1'h0;
      addr_out <= '0;
      addr_oe <= 1'h0;
      data_out <= '0;
      data_oe <= 1'h0;
    end else begin
      state <= next_state;
      grant_sync <= {grant_sync[LBM_SYNC_STAGES-2:0], bus_grant_in};
      trig_prev <= next_trig_prev;
      timer_run <= next_timer_run;
      tenure_cnt <= next_tenure_cnt;
      expired <= next_expired;
      lock_active <= next_lock_active;
      cur_lock_last <= next_cur_lock_last;
      req_ready <= next_req_ready;
      rsp_done <= next_rsp_done;
      rsp_rdata <= next_rsp_rdata;
      bus_owned <= next_bus_owned;
      bus_request <= next_bus_request;
      address_strobe_b <= next_address_strobe_b;
      // R1: pins float whenever the bus is not owned
      address_strobe_oe <= next_bus_owned;
      wr_sel <= next_wr_sel;
      wr_sel_oe <= next_bus_owned;
      lock_b <= next_lock_b;
      lock_oe <= next_bus_owned;
      addr_out <= next_addr_out;
      addr_oe <= next_bus_owned;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_float_unowned: assert property (!bus_owned |-> !wr_sel_oe && !lock_oe && !address_strobe_oe) // R1
    else $error("bus pins driven while bus not owned");
  chk_strobe_one_clk: assert property ($fell(address_strobe_b) |=> address_strobe_b && bus_owned) // R2
    else $error("address strobe not a single clock");
  chk_ready_ignored: assert property (!address_strobe_b && !ready_b_in |=> !rsp_done) // R4
    else $error("ready taken in address state");
  chk_wait_state: assert property (!address_strobe_b ##1 ready_b_in |=> !rsp_done) // R3
    else $error("transfer ended with ready high");
  chk_min_two_clk: assert property (!address_strobe_b ##1 !ready_b_in |=> rsp_done) // R15
    else $error("transfer not done after two clocks");
  chk_lock_disable: assert property (cfg_lock_disable && $stable(cfg_lock_disable) && lock_b |=> lock_b) // R6
    else $error("lock asserted while disabled");
  chk_lock_start: assert property ($fell(lock_b) |-> !address_strobe_b) // R5
    else $error("lock started outside address state");
  chk_req_before_grant: assert property (bus_owned |-> bus_request) // R9
    else $error("bus owned without request");
  chk_release_bound: assert property (bus_owned && !bus_grant_in ##1 !bus_grant_in [*2] ##0 address_strobe_b
    ##0 !(state == LBM_DATA) |-> ##[0:4] !bus_request) // R12
    else $error("request not dropped after grant loss");
  chk_start_granted: assert property ($fell(address_strobe_b) |-> $past(grant_s)) // R16
    else $error("cycle started without grant");
  chk_expiry_release: assert property (expired && state == LBM_OWN |=> state == LBM_REL) // R10
    else $error("no release on throttle expiry");
  chk_ext_trigger: assert property (cfg_throttle_ext && $stable(cfg_throttle_ext) && !timer_run
    && !(throttle_trigger_in && !trig_prev) |=> !timer_run) // R14
    else $error("timer started without trigger");

  cov_read_no_wait: cover property (!address_strobe_b && !wr_sel ##1 !ready_b_in ##1 rsp_done);
  cov_write_wait: cover property (!address_strobe_b && wr_sel ##1 ready_b_in ##1 ready_b_in);
  cov_locked_seq: cover property (!lock_b ##[1:20] $rose(lock_b));
  cov_expiry: cover property (expired && state == LBM_OWN);

endmodule

// ==== shared/lbm_pkg.sv ====
// constants and types for the coprocessor bus master port
//------------------------------------------------------------
// Function
//------------------------------------------------------------
// Function
// R1: drive write/read select per cycle; float it after reset and when bus not owned.
// R2: assert address strobe in the address state of every bus cycle.
// R3: memory drives ready low to finish a transfer; high inserts wait states.
// R4: ready is disregarded at the end of the address state clock.
// R5: lock asserts in first locked address state, drops in last locked data state.
// R6: a configuration bit disables lock; then lock never asserts.
// R7: system holds bus width select static; high is 32-bit, low 16-bit.
// R8: 16-bit data uses low half in little endian, high half in big endian.
// R9: request the bus with an active-high request; drop it before grant falls.
// R10: give up the bus on grant removal or on throttle timer expiry.
// R11: arbiter grants high, drops grant only after seeing request low.
// R12: grant loss while requesting makes the port drop request within bounded clocks.
// R13: permanent access loops grant back from request; never tie grant high.
// R14: in external throttle mode the trigger input starts the throttle timer.
// R15: one address state then data states until ready low; two clocks minimum.
// R16: start cycles only while granted; finish a running cycle before releasing.
package lbm_pkg;

  // grant synchroniser depth
  localparam int LBM_SYNC_STAGES = 2;
  // throttle tenure counter width; a limit of zero means no limit
  localparam int LBM_TIMER_W = 16;
  // clocks from grant loss to request low with no cycle running: sync plus decision
  localparam int LBM_RELEASE_MAX_CLK = 4;
  // bus field widths and reset levels
  localparam int LBM_ADDR_W = 30;
  localparam int LBM_DATA_W = 32;
  localparam int LBM_HALF_W = 16;
  localparam logic LBM_STROBE_IDLE = 1'h1;
  localparam logic LBM_LOCK_IDLE = 1'h1;

  // bus states, gray coded along idle-request-own-address-data-release
  typedef enum logic [2:0] {
    LBM_IDLE = 3'h0,
    LBM_REQ  = 3'h1,
    LBM_OWN  = 3'h3,
    LBM_ADDR = 3'h2,
    LBM_DATA = 3'h6,
    LBM_REL  = 3'h4
  } lbm_state_e;

  // one user transfer request
  typedef struct packed {
    logic write;
    logic locked;
    logic lock_last;
    logic [LBM_ADDR_W-1:0] addr;
    logic [LBM_DATA_W-1:0] wdata;
  } lbm_req_s;

endpackage

// ==== tb/lbm_host_model.sv ====
// host side model: grant loopback arbiter and memory that answers with ready
module lbm_host_model import lbm_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // pins from the port
  input wire logic bus_request,
  input wire logic address_strobe_b,
  input wire logic [LBM_ADDR_W-1:0] addr_out,
  // scenario controls
  input wire logic [3:0] wait_cnt,
  input wire logic grant_kill,
  input wire logic ready_trap,
  // pins into the port
  output logic bus_grant_in,
  output logic ready_b_in,
  output logic [LBM_DATA_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy, req_q, strobe_q, rdy_q;
  logic [LBM_ADDR_W-1:0] a_q;
  int left;
  // sample at the edge, answer 1 ns later
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus_grant_in = 1'b0;
      ready_b_in = 1'b1;
      data_in = '0;
      busy = 1'b0;
    end else begin
      req_q = bus_request;
      strobe_q = address_strobe_b;
      rdy_q = ready_b_in;
      a_q = addr_out;
      #1;
      // grant looped back from request, so it falls after request unless grant_kill forces it low
      bus_grant_in = req_q && !grant_kill;
      if (busy && !rdy_q) begin
        busy = 1'b0;
      end else if (!strobe_q) begin
        busy = 1'b1;
        left = wait_cnt;
      end
      // wait states while high, then ready low with the word
      if (busy && left == 0) begin
        ready_b_in = 1'b0;
        data_in = {~a_q[15:0], a_q[15:0] ^ 16'h3c3c};
      end else begin
        if (busy) left--;
        // no pull-up: outside a data state the line wanders or sits low as a trap
        ready_b_in = busy ? 1'b1 : (ready_trap ? 1'b0 : ~ready_b_in);
        data_in = ~data_in;
      end
    end
  end
endmodule

// ==== tb/lbm_bus_master_port_bench.sv ====
// self-checking bench for the bus master port
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module lbm_bus_master_port_bench import lbm_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, req_valid, req_ready, rsp_done, cfg_lock_disable, cfg_little_endian, cfg_throttle_ext;
  logic bus_owned, bus_request, bus_grant_in, throttle_trigger_in, ready_b_in, bus_width_select, data_oe;
  logic address_strobe_b, wr_sel, wr_sel_oe, lock_b, lock_oe, grant_kill, ready_trap;
  logic address_strobe_oe, addr_oe, hold;
  logic [LBM_TIMER_W-1:0] cfg_tenure_limit;
  logic [LBM_DATA_W-1:0] rsp_rdata, data_out, data_in, w;
  logic [LBM_ADDR_W-1:0] addr_out;
  logic [3:0] wait_cnt;
  lbm_req_s req;
  int fail_count, compares, cycles, seed, run, top, n, m;
  logic [31:0] exp_q[$];

  lbm_bus_master_port u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .cfg_lock_disable(cfg_lock_disable),
    .cfg_little_endian(cfg_little_endian), .cfg_throttle_ext(cfg_throttle_ext),
    .cfg_tenure_limit(cfg_tenure_limit), .bus_owned(bus_owned), .bus_request(bus_request),
    .bus_grant_in(bus_grant_in), .throttle_trigger_in(throttle_trigger_in), .ready_b_in(ready_b_in),
    .bus_width_select(bus_width_select), .address_strobe_b(address_strobe_b), .address_strobe_oe(address_strobe_oe),
    .wr_sel(wr_sel), .wr_sel_oe(wr_sel_oe), .lock_b(lock_b), .lock_oe(lock_oe), .addr_out(addr_out),
    .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));

  lbm_host_model u_host (.clk_sys(clk_sys), .rst_b(rst_b), .bus_request(bus_request),
    .address_strobe_b(address_strobe_b), .addr_out(addr_out), .wait_cnt(wait_cnt), .grant_kill(grant_kill),
    .ready_trap(ready_trap), .bus_grant_in(bus_grant_in), .ready_b_in(ready_b_in), .data_in(data_in));

  // clock, cycle ceiling and longest ownership run
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    run = bus_owned ? run + 1 : 0;
    if (run > top) top = run;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  // one transfer; read data is checked against the expected word held in the queue
  task automatic xfer(input logic wr, input logic lk, input logic last);
    lbm_req_s r;
    int k;
    r = '{wr, lk, last, 30'($random(seed)), 32'($random(seed))};
    req = r;
    req_valid = 1'b1;
    k = 0;
    while (req_ready !== 1'b1 && k < 60) begin
      step();
      k++;
    end
    step();
    // a held request keeps the port owned so only the throttle ends the tenure
    req_valid = hold;
    `CHK(address_strobe_b, 1'b0)
    `CHK({address_strobe_oe, addr_oe, data_oe}, {2'h3, wr})
    `CHK(wr_sel, wr)
    `CHK(addr_out, r.addr)
    `CHK(lock_b, !(lk && !cfg_lock_disable))
    if (wr && bus_width_select) `CHK(data_out, r.wdata)
    else if (wr && cfg_little_endian) `CHK(data_out[15:0], r.wdata[15:0])
    else if (wr) `CHK(data_out[31:16], r.wdata[15:0])
    w = {~r.addr[15:0], r.addr[15:0] ^ 16'h3c3c};
    exp_q.push_back(bus_width_select ? w : {16'h0, cfg_little_endian ? w[15:0] : w[31:16]});
    k = 1;
    while (rsp_done !== 1'b1 && k < 40) begin
      step();
      k++;
    end
    `CHK(k, 3 + wait_cnt)
    if (!wr) `CHK(rsp_rdata, exp_q[0])
    void'(exp_q.pop_front());
    `CHK(lock_b, !(lk && !last && !cfg_lock_disable))
  endtask

  task automatic test_end(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    seed = 31305;
    {rst_b, req_valid, cfg_lock_disable, cfg_throttle_ext, throttle_trigger_in, grant_kill, hold} = '0;
    {cfg_little_endian, bus_width_select, ready_trap} = 3'h7;
    cfg_tenure_limit = '0;
    wait_cnt = '0;
    req = '0;
    repeat (8) @(posedge clk_sys);
    #1;
    rst_b = 1'b1;
    `CHK({bus_request, wr_sel_oe, lock_oe, address_strobe_b}, 4'h1)
    // width and endian modes, lock enabled and disabled, then idle release
    for (m = 0; m < 3; m++) begin
      // width only changes while the port is idle
      bus_width_select = (m == 0);
      cfg_little_endian = (m != 2);
      cfg_lock_disable = (m == 1);
      wait_cnt = 4'($unsigned($random(seed)) % 4);
      xfer(1'b0, 1'b1, 1'b0);
      xfer(1'b1, 1'b1, 1'b1);
      xfer(1'($random(seed)), 1'b0, 1'b0);
      n = 0;
      while (bus_request !== 1'b0 && n < 10) begin
        step();
        n++;
      end
      `CHK(bus_grant_in, 1'b1)
      repeat (4) step();
      `CHK({wr_sel_oe, lock_oe, bus_owned, address_strobe_oe, addr_oe, data_oe}, 6'h0)
      test_end("modes");
    end
    // grant taken away in mid-cycle: cycle ends, then request drops
    wait_cnt = 4'h6;
    fork
      xfer(1'b0, 1'b0, 1'b0);
      begin
        wait (address_strobe_b === 1'b0);
        #1 grant_kill = 1'b1;
      end
    join
    n = 0;
    while (bus_request !== 1'b0 && n < LBM_RELEASE_MAX_CLK + 2) begin
      step();
      n++;
    end
    `CHK(bus_request, 1'b0)
    grant_kill = 1'b0;
    repeat (6) step();
    test_end("grant loss");
    // internal throttle: owned runs are cut short
    wait_cnt = '0;
    cfg_tenure_limit = 16'h0006;
    top = 0;
    // request held so a tenure can only end by expiry
    hold = 1'b1;
    repeat (10) xfer(1'($random(seed)), 1'b0, 1'b0);
    `CHK(top <= 12, 1'b1)
    // let the port go idle before switching the timer mode
    hold = 1'b0;
    req_valid = 1'b0;
    repeat (12) step();
    // external throttle: no expiry until the trigger input rises
    cfg_throttle_ext = 1'b1;
    hold = 1'b1;
    top = 0;
    repeat (8) xfer(1'b1, 1'b0, 1'b0);
    `CHK(top >= 20, 1'b1)
    fork
      repeat (10) xfer(1'b0, 1'b0, 1'b0);
      begin
        throttle_trigger_in = 1'b1;
        step();
        throttle_trigger_in = 1'b0;
        n = 0;
        while (bus_owned === 1'b1 && n < 40) begin
          step();
          n++;
        end
        `CHK(n <= 12, 1'b1)
      end
    join
    test_end("throttle");
    stop_test();
  end
endmodule
